// ==== design/fcd_cfg.svh ====
`ifndef FCD_CFG_SVH
`define FCD_CFG_SVH
// What this block does
// [RULE_01] multi-cycle commands open with AA, 55 unlocks; the bypass program and bypass exit here send none
// [RULE_02] all cycles are writes except data reads
// [RULE_03] address latched at later falling strobe edge
// [RULE_04] data latched at first rising strobe edge
// [RULE_05] array read is one plain read cycle
// [RULE_06] F0 returns device to read mode
// [RULE_07] identification: AA, 55, 90, then a read
// [RULE_08] ident reads hold top address bit zero
// [RULE_09] protect verify: top bit picks sector half
// [RULE_10] protect read at x02 gives 00/01
// [RULE_11] lock read at x06 gives 85/05
// [RULE_12] AA,55,88 enters secure region; 90,00 leaves
// [RULE_13] byte program: AA, 55, A0, address/data
// [RULE_14] AA,55,20 bypass; then A0 plus address/data
// [RULE_15] bypass program only after bypass entry
// [RULE_16] bypass exit: 90 then 00
// [RULE_17] erase: AA,55,80,AA,55, then 10 or 30
// [RULE_18] sector taken from address bits 21..16
// [RULE_19] B0 suspends only during sector erase
// [RULE_20] 30 resumes only while suspended
// [RULE_21] suspended: reads, programs, identification allowed
// [RULE_22] 98 enters query from read or ident
// [RULE_23] unmatched value abandons partial sequence
`define FCD_D_UNLOCK1   8'haa
`define FCD_D_UNLOCK2   8'h55
`define FCD_D_RESET     8'hf0
`define FCD_D_IDENT     8'h90
`define FCD_D_SECURE    8'h88
`define FCD_D_PROGRAM   8'ha0
`define FCD_D_BYPASS    8'h20
`define FCD_D_ERASE     8'h80
`define FCD_D_CHIP      8'h10
`define FCD_D_SECTOR    8'h30
`define FCD_D_SUSPEND   8'hb0
`define FCD_D_RESUME    8'h30
`define FCD_D_QUERY     8'h98
`define FCD_D_EXIT      8'h00
`define FCD_A_MAKER     8'h00
`define FCD_A_DEVICE    8'h01
`define FCD_A_PROTECT   8'h02
`define FCD_A_LOCK      8'h06
`define FCD_TOP_BIT     21
`define FCD_SEC_HI      21
`define FCD_SEC_LO      16
`define FCD_SETUP_NS    100
`define FCD_PULSE_NS    200
`define FCD_CLK_NS      100
`define FCD_SETUP_CYC   ((`FCD_SETUP_NS + `FCD_CLK_NS - 1) / `FCD_CLK_NS)
`define FCD_PULSE_CYC   ((`FCD_PULSE_NS + `FCD_CLK_NS - 1) / `FCD_CLK_NS)
`endif

// ==== design/fcd_pkg.sv ====
package fcd_pkg;
    typedef enum logic [3:0] {
        FCD_OP_READ     = 4'h0,
        FCD_OP_RESET    = 4'h1,
        FCD_OP_IDENT    = 4'h2,
        FCD_OP_SEC_IN   = 4'h3,
        FCD_OP_SEC_OUT  = 4'h4,
        FCD_OP_PROGRAM  = 4'h5,
        FCD_OP_BYP_IN   = 4'h6,
        FCD_OP_BYP_PROG = 4'h7,
        FCD_OP_BYP_OUT  = 4'h8,
        FCD_OP_CHIP_ER  = 4'h9,
        FCD_OP_SECT_ER  = 4'ha,
        FCD_OP_SUSPEND  = 4'hb,
        FCD_OP_RESUME   = 4'hc,
        FCD_OP_QUERY    = 4'hd
    } fcd_op_e;
    typedef struct packed {
        fcd_op_e     op;
        logic [21:0] addr;
        logic [7:0]  data;
    } fcd_req_s;
    typedef struct packed {
        logic       ok;
        logic       refused;
        logic [7:0] data;
    } fcd_rsp_s;
    typedef struct packed {
        logic        write;
        logic [21:0] addr;
        logic [7:0]  data;
    } fcd_cyc_s;
endpackage

// ==== design/fcd_bus_cycle.sv ====
`timescale 1ns/100ps
`include "fcd_cfg.svh"
// one bus cycle on the flash pins: setup, strobe low, strobe high
module fcd_bus_cycle (
    input  wire logic              sys_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              start_i,
    input  wire fcd_pkg::fcd_cyc_s cyc_i,
    input  wire logic [7:0]        dq_sync_i,
    output logic                   done_o,
    output logic [7:0]             rdata_o,
    output logic                   cs_n_o,
    output logic                   we_n_o,
    output logic                   oe_n_o,
    output logic [21:0]            addr_o,
    output logic [7:0]             dq_o,
    output logic                   dq_oe_o
);
    import fcd_pkg::*;
    typedef enum logic [1:0] {
        FCD_BC_IDLE  = 2'b00,
        FCD_BC_SETUP = 2'b01,
        FCD_BC_PULSE = 2'b10,
        FCD_BC_END   = 2'b11
    } fcd_bc_e;
    fcd_bc_e    state;
    logic [3:0] cnt;
    logic       wr;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state   <= FCD_BC_IDLE;
            cnt     <= 4'h0;
            wr      <= 1'b0;
            done_o  <= 1'b0;
            rdata_o <= 8'h00;
            cs_n_o  <= 1'b1;
            we_n_o  <= 1'b1;
            oe_n_o  <= 1'b1;
            addr_o  <= 22'h000000;
            dq_o    <= 8'h00;
            dq_oe_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            case (state)
                FCD_BC_IDLE: begin
                    if (start_i) begin
                        wr      <= cyc_i.write;
                        addr_o  <= cyc_i.addr;
                        dq_o    <= cyc_i.data;
                        dq_oe_o <= cyc_i.write; // [RULE_02]
                        cs_n_o  <= 1'b0;
                        cnt     <= 4'(`FCD_SETUP_CYC);
                        state   <= FCD_BC_SETUP;
                    end
                end
                FCD_BC_SETUP: begin
                    if (cnt == 4'h1) begin
                        // strobe falls after select: address taken here
                        we_n_o <= ~wr; // [RULE_03]
                        oe_n_o <= wr;
                        cnt    <= 4'(`FCD_PULSE_CYC);
                        state  <= FCD_BC_PULSE;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                FCD_BC_PULSE: begin
                    if (cnt == 4'h1) begin
                        // strobe rises before select: data taken here
                        we_n_o  <= 1'b1; // [RULE_04]
                        oe_n_o  <= 1'b1;
                        state   <= FCD_BC_END;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                default: begin
                    cs_n_o  <= 1'b1;
                    dq_oe_o <= 1'b0;
                    rdata_o <= dq_sync_i;
                    done_o  <= 1'b1;
                    state   <= FCD_BC_IDLE;
                end
            endcase
        end
    end

    a_strobe_order: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $fell(we_n_o) |-> !cs_n_o && $past(!cs_n_o)) // [RULE_03]
        else $error("write strobe fell without prior select");
    a_data_held: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $rose(we_n_o) |-> !cs_n_o && dq_oe_o) // [RULE_04]
        else $error("select or data released before strobe rose");
endmodule // fcd_bus_cycle

// ==== design/fcd_host.sv ====
`timescale 1ns/100ps
`include "fcd_cfg.svh"
// host controller: turns one request into the flash's cycle sequence
module fcd_host (
    input  wire logic              sys_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              req_valid_i,
    input  wire fcd_pkg::fcd_req_s req_i,
    input  wire logic [7:0]        dq_i,
    input  wire logic              timeout_error_flag_i,
    output logic                   req_ready_o,
    output fcd_pkg::fcd_rsp_s      rsp_o,
    output logic                   rsp_valid_o,
    output logic                   bypass_o,
    output logic                   suspended_o,
    output logic                   secure_o,
    output logic                   cs_n_o,
    output logic                   we_n_o,
    output logic                   oe_n_o,
    output logic [21:0]            addr_o,
    output logic [7:0]             dq_o,
    output logic                   dq_oe_o
);
    import fcd_pkg::*;
    typedef enum logic [1:0] {
        FCD_ST_IDLE = 2'b00,
        FCD_ST_RUN  = 2'b01,
        FCD_ST_WAIT = 2'b10
    } fcd_st_e;
    typedef enum logic [1:0] {
        FCD_MD_READ   = 2'b00,
        FCD_MD_IDENT  = 2'b01,
        FCD_MD_QUERY  = 2'b10
    } fcd_md_e;

    fcd_st_e    state;
    fcd_md_e    mode;
    fcd_req_s   cur;
    logic [2:0] idx;
    logic [2:0] len;
    logic       start;
    fcd_cyc_s   cyc;
    logic       done;
    logic [7:0] rdata;
    logic [7:0] dq_meta;
    logic [7:0] dq_sync;
    logic       to_meta;
    logic       to_sync;
    logic       erasing;

    // single write cycle with the given address and data
    function automatic fcd_cyc_s wcyc(input logic [21:0] a, input logic [7:0] d);
        fcd_cyc_s c;
        c.write = 1'b1;
        c.addr  = a;
        c.data  = d;
        return c;
    endfunction

    // number of bus cycles per operation
    function automatic logic [2:0] op_len(input fcd_op_e op);
        case (op)
            FCD_OP_READ, FCD_OP_RESET, FCD_OP_SUSPEND,
            FCD_OP_RESUME, FCD_OP_QUERY:                 op_len = 3'd1;
            FCD_OP_BYP_PROG, FCD_OP_BYP_OUT:             op_len = 3'd2;
            FCD_OP_SEC_IN, FCD_OP_BYP_IN:                op_len = 3'd3;
            FCD_OP_CHIP_ER, FCD_OP_SECT_ER:              op_len = 3'd6;
            default:                                     op_len = 3'd4;
        endcase
    endfunction

    // the pin inputs pass two flip-flops
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            dq_meta <= 8'h00;
            dq_sync <= 8'h00;
            to_meta <= 1'b0;
            to_sync <= 1'b0;
        end else begin
            dq_meta <= dq_i;
            dq_sync <= dq_meta;
            to_meta <= timeout_error_flag_i;
            to_sync <= to_meta;
        end
    end

    // whether a request is legal in the present mode
    function automatic logic legal(input fcd_op_e op);
        case (op)
            FCD_OP_BYP_PROG, FCD_OP_BYP_OUT: legal = bypass_o; // [RULE_15]
            FCD_OP_SUSPEND:  legal = erasing && !suspended_o;  // [RULE_19]
            FCD_OP_RESUME:   legal = suspended_o;              // [RULE_20]
            FCD_OP_QUERY:    legal = !bypass_o && (mode != FCD_MD_QUERY); // [RULE_22]
            FCD_OP_CHIP_ER, FCD_OP_SECT_ER, FCD_OP_BYP_IN:
                             legal = !bypass_o && !suspended_o; // [RULE_21]
            FCD_OP_RESET:    legal = 1'b1;
            default:         legal = !bypass_o;
        endcase
    endfunction

    // cycle idx of the current request
    always_comb begin
        cyc = wcyc(22'h000000, `FCD_D_UNLOCK1); // [RULE_01]
        if (cur.op == FCD_OP_READ) begin
            cyc.write = 1'b0; // [RULE_05]
            cyc.addr  = cur.addr;
        end else if (cur.op == FCD_OP_RESET) begin
            cyc.data = `FCD_D_RESET; // [RULE_06]
        end else if (cur.op == FCD_OP_SUSPEND) begin
            cyc.data = `FCD_D_SUSPEND;
        end else if (cur.op == FCD_OP_RESUME) begin
            cyc.data = `FCD_D_RESUME;
        end else if (cur.op == FCD_OP_QUERY) begin
            cyc.data = `FCD_D_QUERY;
        end else if (cur.op == FCD_OP_BYP_PROG) begin
            if (idx == 3'd0) cyc.data = `FCD_D_PROGRAM; // [RULE_14]
            else cyc = wcyc(cur.addr, cur.data);
        end else if (cur.op == FCD_OP_BYP_OUT) begin
            cyc.data = (idx == 3'd0) ? `FCD_D_IDENT : `FCD_D_EXIT; // [RULE_16]
        end else if (idx == 3'd1 || idx == 3'd4) begin
            cyc.data = `FCD_D_UNLOCK2; // [RULE_01]
        end else if (idx == 3'd2) begin
            // top bit kept for identification and protect verify
            cyc.addr[`FCD_TOP_BIT] = cur.addr[`FCD_TOP_BIT]; // [RULE_08] [RULE_09]
            case (cur.op)
                FCD_OP_SEC_IN:  cyc.data = `FCD_D_SECURE;  // [RULE_12]
                FCD_OP_PROGRAM: cyc.data = `FCD_D_PROGRAM; // [RULE_13]
                FCD_OP_BYP_IN:  cyc.data = `FCD_D_BYPASS;  // [RULE_14]
                FCD_OP_CHIP_ER, FCD_OP_SECT_ER: cyc.data = `FCD_D_ERASE; // [RULE_17]
                default:        cyc.data = `FCD_D_IDENT;   // [RULE_07]
            endcase
        end else if (idx == 3'd3) begin
            if (cur.op == FCD_OP_IDENT) begin
                cyc.write = 1'b0; // [RULE_07]
                cyc.addr  = cur.addr;
            end else if (cur.op == FCD_OP_SEC_OUT) begin
                cyc.data = `FCD_D_EXIT; // [RULE_12]
            end else if (cur.op == FCD_OP_PROGRAM) begin
                cyc = wcyc(cur.addr, cur.data); // [RULE_13]
            end
        end else if (idx == 3'd5) begin
            if (cur.op == FCD_OP_SECT_ER) begin
                cyc.addr[`FCD_SEC_HI:`FCD_SEC_LO] = cur.addr[`FCD_SEC_HI:`FCD_SEC_LO]; // [RULE_18]
                cyc.data = `FCD_D_SECTOR;
            end else begin
                cyc.data = `FCD_D_CHIP; // [RULE_17]
            end
        end
    end

    fcd_bus_cycle u_cycle (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .start_i   (start),
        .cyc_i     (cyc),
        .dq_sync_i (dq_sync),
        .done_o    (done),
        .rdata_o   (rdata),
        .cs_n_o    (cs_n_o),
        .we_n_o    (we_n_o),
        .oe_n_o    (oe_n_o),
        .addr_o    (addr_o),
        .dq_o      (dq_o),
        .dq_oe_o   (dq_oe_o)
    );

    // sequencer
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state       <= FCD_ST_IDLE;
            cur         <= '0;
            idx         <= 3'd0;
            len         <= 3'd1;
            start       <= 1'b0;
            req_ready_o <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_o       <= '0;
        end else begin
            start       <= 1'b0;
            rsp_valid_o <= 1'b0;
            case (state)
                FCD_ST_IDLE: begin
                    req_ready_o <= 1'b1;
                    if (req_valid_i && req_ready_o) begin
                        req_ready_o <= 1'b0;
                        if (legal(req_i.op)) begin
                            cur   <= req_i;
                            idx   <= 3'd0;
                            len   <= op_len(req_i.op);
                            start <= 1'b1;
                            state <= FCD_ST_RUN;
                        end else begin
                            // refused before any cycle: nothing partial on the pins
                            rsp_o       <= '{ok: 1'b0, refused: 1'b1, data: 8'h00}; // [RULE_23]
                            rsp_valid_o <= 1'b1;
                        end
                    end
                end
                FCD_ST_RUN: begin
                    state <= FCD_ST_WAIT;
                end
                default: begin
                    if (done) begin
                        if (idx + 3'd1 == len) begin
                            rsp_o       <= '{ok: 1'b1, refused: 1'b0, data: rdata};
                            rsp_valid_o <= 1'b1;
                            state       <= FCD_ST_IDLE;
                        end else begin
                            idx   <= idx + 3'd1;
                            start <= 1'b1;
                            state <= FCD_ST_RUN;
                        end
                    end
                end
            endcase
        end
    end

    // mode tracking of the device outside
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            mode        <= FCD_MD_READ;
            bypass_o    <= 1'b0;
            suspended_o <= 1'b0;
            secure_o    <= 1'b0;
            erasing     <= 1'b0;
        end else if (done && state == FCD_ST_WAIT && idx + 3'd1 == len) begin
            case (cur.op)
                FCD_OP_RESET: begin
                    mode     <= FCD_MD_READ; // [RULE_06]
                    bypass_o <= 1'b0;
                    suspended_o <= 1'b0;
                    erasing  <= 1'b0;
                end
                FCD_OP_IDENT:   mode     <= FCD_MD_IDENT;
                FCD_OP_QUERY:   mode     <= FCD_MD_QUERY;
                FCD_OP_SEC_IN:  secure_o <= 1'b1; // [RULE_12]
                FCD_OP_SEC_OUT: begin
                    secure_o <= 1'b0;
                    mode     <= FCD_MD_READ;
                end
                FCD_OP_BYP_IN:  bypass_o <= 1'b1; // [RULE_14]
                FCD_OP_BYP_OUT: bypass_o <= 1'b0; // [RULE_16]
                FCD_OP_SECT_ER: erasing  <= 1'b1;
                FCD_OP_SUSPEND: suspended_o <= 1'b1; // [RULE_19]
                FCD_OP_RESUME:  suspended_o <= 1'b0; // [RULE_20]
                default: begin
                end
            endcase
        end else if (to_sync && !suspended_o) begin
            erasing <= 1'b0;
        end
    end

    a_unlock_first: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (state == FCD_ST_RUN && len > 3'd2 && idx == 3'd0) |-> cyc.data == 8'haa) // [RULE_01]
        else $error("long sequence not opened by first unlock");
    a_unlock_second: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (state == FCD_ST_RUN && len > 3'd2 && idx == 3'd1) |-> cyc.data == 8'h55) // [RULE_01]
        else $error("second unlock value wrong");
    a_bypass_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (state == FCD_ST_RUN && cur.op == FCD_OP_BYP_PROG) |-> bypass_o) // [RULE_15]
        else $error("bypass program outside bypass mode");
    a_suspend_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (state == FCD_ST_RUN && cur.op == FCD_OP_RESUME) |-> suspended_o) // [RULE_20]
        else $error("resume issued while not suspended");
    a_refuse_quiet: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (rsp_valid_o && rsp_o.refused) |-> cs_n_o && $past(cs_n_o, 2)) // [RULE_23]
        else $error("refused request touched the pins");
    a_ident_read: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (state == FCD_ST_RUN && cur.op == FCD_OP_IDENT && idx == 3'd3) |-> !cyc.write) // [RULE_07]
        else $error("identification fourth cycle not a read");
    a_reset_mode: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (done && state == FCD_ST_WAIT && cur.op == FCD_OP_RESET) |=> !bypass_o) // [RULE_06]
        else $error("reset left bypass mode set");
    a_sector_addr: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (state == FCD_ST_RUN && cur.op == FCD_OP_SECT_ER && idx == 3'd5)
        |-> cyc.addr[21:16] == cur.addr[21:16] && cyc.data == 8'h30) // [RULE_18]
        else $error("sector erase final cycle wrong");
endmodule // fcd_host

// ==== test/fcd_flash_model.sv ====
`timescale 1ns/100ps
// behavioural flash: decodes write sequences, answers reads
module fcd_flash_model #(
    parameter logic [7:0] MAKER_CODE  = 8'h3c, // arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'hc5, // arbitrary value
    parameter logic       LOCKED      = 1'b1
) (
    input  wire logic        cs_n_i,
    input  wire logic        we_n_i,
    input  wire logic        oe_n_i,
    input  wire logic [21:0] addr_i,
    input  wire logic [7:0]  hdq_i,
    input  wire logic        hdq_oe_i,
    output logic [7:0]       dq_o
);
    logic [21:0] lat_a = '0;
    logic [21:0] pa    = '0;
    logic [7:0]  pd    = '0;
    logic [7:0]  rd;
    logic [7:0]  lastv = '0;
    logic [5:0]  er_sec = '0;
    logic        ident = 0, bypass = 0, secure = 0, erasing = 0;
    logic        chip = 0, suspended = 0, query = 0, id_top = 0;
    int          st = 0, nwr = 0, nprog = 0, nbad = 0;
    wire         wstb = cs_n_i | we_n_i;
    wire         drv  = !cs_n_i && !oe_n_i;

    always_comb begin
        rd = addr_i[7:0] ^ addr_i[15:8] ^ {2'h0, addr_i[21:16]};
        if (ident) begin
            case (addr_i[7:0])
                8'h00: rd = id_top ? 8'hee : MAKER_CODE;
                8'h01: rd = id_top ? 8'hee : DEVICE_CODE;
                8'h02: rd = (id_top != addr_i[21]) ? 8'hee : {7'h00, addr_i[16]};
                8'h06: rd = LOCKED ? 8'h85 : 8'h05;
                default: rd = 8'hee;
            endcase
        end
        if (query) rd = 8'h51;
    end

    // released bus shows the inverse of its last value
    assign dq_o = hdq_oe_i ? hdq_i : (drv ? rd : ~lastv);
    always @(hdq_oe_i or drv or hdq_i or rd) if (hdq_oe_i || drv) lastv = hdq_oe_i ? hdq_i : rd;
    always @(drv or hdq_oe_i) if (drv && hdq_oe_i) nbad++;

    always @(negedge wstb) lat_a = addr_i;

    always @(posedge wstb) begin
        nwr++;
        case (st)
            0: if (bypass) begin
                st = (hdq_i == 8'ha0) ? 7 : (hdq_i == 8'h90) ? 8 : 0;
            end else begin
                case (hdq_i)
                    8'haa: st = 1;
                    8'hf0: {ident, query, erasing, chip, suspended} = 5'h00;
                    8'h00: {ident, secure} = {1'b0, secure & ~ident};
                    8'hb0: {erasing, suspended} = {erasing & chip, suspended | (erasing & ~chip)};
                    8'h30: {erasing, suspended} = {erasing | suspended, 1'b0};
                    8'h98: query = query | ~erasing;
                    default: ;
                endcase
            end
            1: st = (hdq_i == 8'h55) ? 2 : 0;
            2: begin
                st = 0;
                case (hdq_i)
                    8'h90: {ident, id_top} = {1'b1, lat_a[21]};
                    8'h88: secure = 1;
                    8'ha0: st = 7;
                    8'h20: bypass = 1;
                    8'h80: st = 3;
                    default: ;
                endcase
            end
            3: st = (hdq_i == 8'haa) ? 4 : 0;
            4: st = (hdq_i == 8'h55) ? 5 : 0;
            5: begin
                st = 0;
                if (hdq_i == 8'h10 || hdq_i == 8'h30)
                    {erasing, chip, er_sec} = {1'b1, hdq_i == 8'h10, lat_a[21:16]};
            end
            7: begin
                {pa, pd} = {lat_a, hdq_i};
                nprog++;
                st = 0;
            end
            default: begin
                st = 0;
                if (hdq_i == 8'h00) bypass = 0;
            end
        endcase
    end
endmodule // fcd_flash_model

// ==== test/fcd_host_bench.sv ====
`timescale 1ns/100ps
module fcd_host_bench;
    import fcd_pkg::*;
    localparam logic [7:0] MAKER = 8'h3c; // arbitrary value
    localparam logic [7:0] DEVID = 8'hc5; // arbitrary value
    localparam logic [7:0] IDL [4] = '{8'h00, 8'h01, 8'h02, 8'h06};
    logic        sys_clk, rst_n, req_valid, timeout_flag;
    logic        req_ready, rsp_valid, bypass, suspended, secure;
    logic        cs_n, we_n, oe_n, dq_oe;
    fcd_req_s    req;
    fcd_rsp_s    rsp, got;
    logic [21:0] addr, a;
    logic [7:0]  dq_in, dq_out, d;
    logic [31:0] seed = 32'h00016b0c;
    logic [31:0] r;
    int          n_errors = 0, n_checks = 0, dw;

    fcd_host fcd_host_i (
        .sys_clk_i(sys_clk), .rst_n_i(rst_n), .req_valid_i(req_valid), .req_i(req),
        .dq_i(dq_in), .timeout_error_flag_i(timeout_flag), .req_ready_o(req_ready),
        .rsp_o(rsp), .rsp_valid_o(rsp_valid), .bypass_o(bypass), .suspended_o(suspended),
        .secure_o(secure), .cs_n_o(cs_n), .we_n_o(we_n), .oe_n_o(oe_n), .addr_o(addr),
        .dq_o(dq_out), .dq_oe_o(dq_oe));
    fcd_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVID), .LOCKED(1'b1)) fcd_flash_model_i (
        .cs_n_i(cs_n), .we_n_i(we_n), .oe_n_i(oe_n), .addr_i(addr), .hdq_i(dq_out),
        .hdq_oe_i(dq_oe), .dq_o(dq_in));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] arr(input logic [21:0] x);
        return x[7:0] ^ x[15:8] ^ {2'h0, x[21:16]};
    endfunction
    function automatic logic [7:0] idv(input logic [21:0] x);
        case (x[7:0])
            8'h00: return MAKER;
            8'h01: return DEVID;
            8'h02: return {7'h00, x[16]};
            default: return 8'h85;
        endcase
    endfunction

    task automatic print_verdict();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic run(input fcd_op_e op, input logic [21:0] ad, input logic [7:0] dt,
                       input logic rf);
        int i;
        int w;
        w = fcd_flash_model_i.nwr;
        @(negedge sys_clk);
        req_valid = 1'b1;
        req = '{op, ad, dt};
        i = 0;
        while (req_ready !== 1'b1 && i < 3000) begin
            @(negedge sys_clk);
            i++;
        end
        @(negedge sys_clk);
        req_valid = 1'b0;
        while (rsp_valid !== 1'b1 && i < 3000) begin
            @(negedge sys_clk);
            i++;
        end
        got = rsp;
        dw = fcd_flash_model_i.nwr - w;
        if (i >= 3000) begin
            n_errors++;
            print_verdict();
        end
        chk({got.ok, got.refused}, {~rf, rf});
        if (rf) chk(dw, 0);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    initial begin
        {rst_n, req_valid, timeout_flag} = 3'h0;
        req = '0;
        repeat (4) @(negedge sys_clk);
        rst_n = 1'b1;
        for (int k = 0; k < 6; k++) begin
            r = rnd();
            a = r[21:0];
            d = r[31:24];
            run(FCD_OP_READ, a, 8'h00, 1'b0);
            chk({got.data, dw}, {arr(a), 32'd0});
            run(FCD_OP_PROGRAM, a, d, 1'b0);
            chk({fcd_flash_model_i.pa, fcd_flash_model_i.pd, dw}, {a, d, 32'd4});
        end
        for (int j = 0; j < 8; j++) begin
            r = rnd();
            a = {r[21:16], 8'h00, IDL[j%4]};
            a[21] = (IDL[j%4] == 8'h02) ? r[0] : 1'b0;
            run(FCD_OP_IDENT, a, 8'h00, 1'b0);
            chk(got.data, idv(a));
            run(FCD_OP_RESET, 22'h0, 8'h00, 1'b0);
            chk(fcd_flash_model_i.ident, 1'b0);
        end
        run(FCD_OP_BYP_PROG, a, d, 1'b1);
        run(FCD_OP_BYP_OUT, 22'h0, 8'h00, 1'b1);
        run(FCD_OP_SUSPEND, 22'h0, 8'h00, 1'b1);
        run(FCD_OP_RESUME, 22'h0, 8'h00, 1'b1);
        run(FCD_OP_BYP_IN, 22'h0, 8'h00, 1'b0);
        chk({bypass, fcd_flash_model_i.bypass, dw}, {2'b11, 32'd3});
        run(FCD_OP_PROGRAM, a, d, 1'b1);
        run(FCD_OP_QUERY, 22'h0, 8'h00, 1'b1);
        for (int k = 0; k < 3; k++) begin
            r = rnd();
            run(FCD_OP_BYP_PROG, r[21:0], r[31:24], 1'b0);
            chk({fcd_flash_model_i.pa, fcd_flash_model_i.pd, dw}, {r[21:0], r[31:24], 32'd2});
        end
        run(FCD_OP_BYP_OUT, 22'h0, 8'h00, 1'b0);
        chk({bypass, fcd_flash_model_i.bypass, dw}, {2'b00, 32'd2});
        run(FCD_OP_SECT_ER, {6'h25, 16'h0000}, 8'h00, 1'b0);
        chk({fcd_flash_model_i.erasing, fcd_flash_model_i.chip, fcd_flash_model_i.er_sec, dw},
            {2'b10, 6'h25, 32'd6});
        run(FCD_OP_SUSPEND, 22'h0, 8'h00, 1'b0);
        chk({suspended, fcd_flash_model_i.suspended}, 2'b11);
        r = rnd();
        a = {6'h01, r[15:0]};
        run(FCD_OP_READ, a, 8'h00, 1'b0);
        chk(got.data, arr(a));
        run(FCD_OP_PROGRAM, a, r[23:16], 1'b0);
        chk({fcd_flash_model_i.pa, fcd_flash_model_i.pd}, {a, r[23:16]});
        run(FCD_OP_RESUME, 22'h0, 8'h00, 1'b0);
        chk({suspended, fcd_flash_model_i.suspended, fcd_flash_model_i.erasing}, 3'b001);
        run(FCD_OP_RESUME, 22'h0, 8'h00, 1'b1);
        run(FCD_OP_SUSPEND, 22'h0, 8'h00, 1'b0);
        run(FCD_OP_IDENT, 22'h0, 8'h00, 1'b0);
        chk(got.data, MAKER);
        run(FCD_OP_RESET, 22'h0, 8'h00, 1'b0);
        run(FCD_OP_CHIP_ER, 22'h0, 8'h00, 1'b0);
        chk({fcd_flash_model_i.erasing, fcd_flash_model_i.chip, dw}, {2'b11, 32'd6});
        run(FCD_OP_SUSPEND, 22'h0, 8'h00, 1'b1);
        run(FCD_OP_RESET, 22'h0, 8'h00, 1'b0);
        run(FCD_OP_SECT_ER, {6'h02, 16'h0000}, 8'h00, 1'b0);
        @(negedge sys_clk);
        timeout_flag = 1'b1;
        repeat (4) @(negedge sys_clk);
        run(FCD_OP_SUSPEND, 22'h0, 8'h00, 1'b1);
        @(negedge sys_clk);
        timeout_flag = 1'b0;
        run(FCD_OP_RESET, 22'h0, 8'h00, 1'b0);
        chk(fcd_flash_model_i.erasing, 1'b0);
        run(FCD_OP_QUERY, 22'h0, 8'h00, 1'b0);
        chk(fcd_flash_model_i.query, 1'b1);
        run(FCD_OP_QUERY, 22'h0, 8'h00, 1'b1);
        run(FCD_OP_RESET, 22'h0, 8'h00, 1'b0);
        run(FCD_OP_SEC_IN, 22'h0, 8'h00, 1'b0);
        chk({secure, fcd_flash_model_i.secure, dw}, {2'b11, 32'd3});
        run(FCD_OP_SEC_OUT, 22'h0, 8'h00, 1'b0);
        chk({secure, fcd_flash_model_i.secure, dw}, {2'b00, 32'd4});
        chk(fcd_flash_model_i.nbad, 0);
        print_verdict();
    end
endmodule // fcd_host_bench
